// file: rtl/sysc_pkg.sv
// Constants shared by the system control register block
// Notes on behaviour
// - Reset-control writes need key 0x05fa in 31:16
// - Bit 15 reads data endianness, read-only
// - Keyed write of bit 2 requests system reset
// - Wake-any bit lets disabled interrupts wake
// - Pending event wakes wait, or is latched
// - Send-event instruction also wakes a wait
// - Deep-select bit chooses sleep or deep sleep
// - Sleep-after-return bit sleeps on handler exit
// - Configuration register is read-only, ignores writes
// - Configuration bit 9 always reads one
// - Stack adjustment kept in status bit 9
// - Bit 3 reads one; unaligned access faults
package sysc_pkg;
    localparam logic [4:0]  OFS_APP_INTERRUPT_RESET_CTRL = 5'h00;
    localparam logic [4:0]  OFS_SYSTEM_CTRL              = 5'h04;
    localparam logic [4:0]  OFS_CORE_CONFIG_CTRL         = 5'h08;
    localparam logic [4:0]  OFS_WAKE_STATUS              = 5'h0c;
    localparam logic [15:0] REGISTER_WRITE_KEY           = 16'h05fa;
    localparam int          KEY_LSB                      = 16;
    localparam int          DATA_ENDIAN_FLAG_BIT         = 15;
    localparam int          SYSTEM_RESET_REQUEST_BIT     = 2;
    localparam int          DEBUG_CLEAR_ACTIVE_BIT       = 1;
    localparam int          WAKE_ON_ANY_PENDING_BIT      = 4;
    localparam int          DEEP_LOW_POWER_SELECT_BIT    = 2;
    localparam int          SLEEP_AFTER_RETURN_BIT       = 1;
    localparam int          STACK_ALIGN_INDICATOR_BIT    = 9;
    localparam int          MISALIGNED_FAULT_BIT         = 3;
    localparam int          STATUS_WAITING_BIT           = 0;
    localparam int          STATUS_LATCHED_BIT           = 1;
    localparam logic [31:0] CORE_CONFIG_VALUE            = 32'h0000_0208;
    localparam logic        SYSTEM_CTRL_RESET            = 1'b0;
    localparam logic [1:0]  SIZE_BYTE                    = 2'h0;
    localparam logic [1:0]  SIZE_HALF                    = 2'h1;
endpackage

// file: rtl/sysc_wake_latch.sv
// Event latch and wait-state tracker for the wait-for-event instruction
`timescale 1ns/100ps
`default_nettype none
module sysc_wake_latch
    import sysc_pkg::*;
(
    input  wire logic clk_in,          // Processor clock
    input  wire logic reset_n_in,      // Async reset, active low
    input  wire logic ce_in,           // Clock enable
    input  wire logic pend_rise_in,    // Qualified interrupt became pending
    input  wire logic event_in,        // Enabled event pulse
    input  wire logic send_event_in,   // Send-event instruction executed
    input  wire logic wait_enter_in,   // Wait-for-event instruction executed
    output logic      waiting_out,     // Core held in wait state
    output logic      wake_out,        // One-cycle wake pulse
    output logic      latched_out      // Event registered for next wait
);
    typedef enum logic {SYSC_RUN, SYSC_WAIT} sysc_wait_e;

    sysc_wait_e state;
    logic       any_event;

    assign any_event = pend_rise_in | event_in | send_event_in;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state       <= SYSC_RUN;
            wake_out    <= 1'b0;
            latched_out <= 1'b0;
        end else if (ce_in) begin
            wake_out <= 1'b0;
            case (state)
                SYSC_RUN: begin
                    if (wait_enter_in) begin
                        if (latched_out || any_event) begin
                            // Wait returns at once; a fresh event stays latched only if one was already latched
                            wake_out    <= 1'b1;
                            latched_out <= latched_out & any_event;
                        end else begin
                            state <= SYSC_WAIT;
                        end
                    end else if (any_event) begin
                        latched_out <= 1'b1;
                    end
                end
                SYSC_WAIT: begin
                    if (any_event) begin
                        wake_out <= 1'b1;
                        state    <= SYSC_RUN;
                    end
                end
                default: state <= SYSC_RUN;
            endcase
        end
    end

    assign waiting_out = (state == SYSC_WAIT);

    a_wait_send_wake: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && waiting_out && send_event_in) |=> wake_out)
        else $error("send event did not wake waiting core");
    a_latch_fast_return: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && !waiting_out && latched_out && wait_enter_in)
        |=> (wake_out && !waiting_out))
        else $error("latched event did not end the wait at once");
endmodule
`default_nettype wire

// file: rtl/sysc_stack_align.sv
// Stack alignment on exception entry and its undo on exception return
`timescale 1ns/100ps
`default_nettype none
module sysc_stack_align
    import sysc_pkg::*;
(
    input  wire logic        clk_in,         // Processor clock
    input  wire logic        reset_n_in,     // Async reset, active low
    input  wire logic        ce_in,          // Clock enable
    input  wire logic        entry_in,       // Exception entry pulse
    input  wire logic        return_in,      // Exception return pulse
    input  wire logic [31:0] sp_in,          // Stack pointer now
    input  wire logic        stacked_bit_in, // Stacked status bit 9
    output logic [31:0]      sp_out,         // Adjusted stack pointer
    output logic             status_bit_out  // Bit 9 for stacked status
);
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sp_out         <= 32'h0000_0000;
            status_bit_out <= 1'b0;
        end else if (ce_in) begin
            if (entry_in) begin
                // Align down to eight bytes and record bit 2 of the old pointer
                sp_out         <= {sp_in[31:3], 3'h0};
                status_bit_out <= sp_in[2];
            end else if (return_in) begin
                sp_out <= sp_in | {29'h0, stacked_bit_in, 2'h0};
            end
        end
    end

    a_stack_record: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && entry_in) |=> (status_bit_out == $past(sp_in[2])
        && sp_out[2:0] == 3'h0))
        else $error("stack adjustment not recorded");
    a_stack_restore: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && return_in && !entry_in && stacked_bit_in) |=> sp_out[2])
        else $error("stack alignment not restored");
endmodule
`default_nettype wire

// file: rtl/sysc_regs.sv
// System control register bank: reset control, low power, configuration
`timescale 1ns/100ps
`default_nettype none
module sysc_regs
    import sysc_pkg::*;
#(
    parameter int   NUM_IRQ    = 32,   // Interrupt lines watched for wake
    parameter logic BIG_ENDIAN = 1'b0  // Implemented data endianness
)(
    input  wire logic               clk_in,             // Processor clock
    input  wire logic               reset_n_in,         // Async reset, low
    input  wire logic               ce_in,              // Clock enable
    input  wire logic [4:0]         avs_address_in,     // Byte address
    input  wire logic               avs_read_in,        // Read strobe
    input  wire logic               avs_write_in,       // Write strobe
    input  wire logic [31:0]        avs_writedata_in,   // Write data
    input  wire logic [3:0]         avs_byteenable_in,  // Byte lanes
    output logic [31:0]             avs_readdata_out,   // Read data
    output logic                    avs_waitrequest_out,// Stall, high
    input  wire logic [NUM_IRQ-1:0] irq_pending_in,     // Pending lines
    input  wire logic [NUM_IRQ-1:0] irq_enable_in,      // Enable lines
    input  wire logic               event_in,           // Enabled event
    input  wire logic               send_event_in,      // Send event
    input  wire logic               wait_enter_in,      // Wait for event
    input  wire logic               sleep_enter_in,     // Wait for irq
    input  wire logic               handler_return_in,  // Return to thread
    input  wire logic               exc_entry_in,       // Exception entry
    input  wire logic               exc_return_in,      // Exception return
    input  wire logic [31:0]        sp_in,              // Stack pointer
    input  wire logic               stacked_bit_in,     // Stacked bit 9
    input  wire logic               data_access_in,     // Data access
    input  wire logic [1:0]         data_addr_in,       // Low address bits
    input  wire logic [1:0]         data_size_in,       // Access size
    output logic                    sys_reset_req_out,  // Reset request
    output logic                    sleep_out,          // Enter low power
    output logic                    deep_sleep_out,     // Deep mode chosen
    output logic                    waiting_out,        // In wait state
    output logic                    wake_out,           // Wake pulse
    output logic [31:0]             sp_out,             // Adjusted stack
    output logic                    status_bit_out,     // Status bit 9
    output logic                    hard_fault_out      // Fault pulse
);
    logic               wake_on_any_pending;
    logic               deep_low_power_select;
    logic               sleep_after_handler_return;
    logic [NUM_IRQ-1:0] qual_prev;
    logic [NUM_IRQ-1:0] qual_now;
    logic               pend_rise;
    logic               accept;
    logic               wr_ok;
    logic               key_ok;
    logic               misaligned;
    logic               wait_raw;
    logic               wake_raw;
    logic               latched;
    logic [31:0]        next_readdata;

    // Bus accept: one cycle of waitrequest low per request
    assign accept = (avs_read_in | avs_write_in) & !avs_waitrequest_out;
    assign wr_ok  = accept & avs_write_in & (avs_byteenable_in == 4'hf);
    assign key_ok = (avs_writedata_in[31:KEY_LSB]
                    == REGISTER_WRITE_KEY);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            avs_waitrequest_out <= 1'b1;
        end else if (ce_in) begin
            avs_waitrequest_out <= !((avs_read_in | avs_write_in)
                                     & avs_waitrequest_out);
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address_in)
            OFS_APP_INTERRUPT_RESET_CTRL: begin
                // Key field, reset request and debug bit read as zero
                next_readdata[DATA_ENDIAN_FLAG_BIT] = BIG_ENDIAN;
                next_readdata[SYSTEM_RESET_REQUEST_BIT] = 1'b0;
                next_readdata[DEBUG_CLEAR_ACTIVE_BIT] = 1'b0;
            end
            OFS_SYSTEM_CTRL: begin
                next_readdata[WAKE_ON_ANY_PENDING_BIT]   = wake_on_any_pending;
                next_readdata[DEEP_LOW_POWER_SELECT_BIT] =
                    deep_low_power_select;
                next_readdata[SLEEP_AFTER_RETURN_BIT]    =
                    sleep_after_handler_return;
            end
            OFS_CORE_CONFIG_CTRL: begin
                next_readdata = CORE_CONFIG_VALUE;
            end
            OFS_WAKE_STATUS: begin
                next_readdata[STATUS_WAITING_BIT] = wait_raw;
                next_readdata[STATUS_LATCHED_BIT] = latched;
            end
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (ce_in) begin
            if (avs_read_in && avs_waitrequest_out) begin
                avs_readdata_out <= next_readdata;
            end
        end
    end

    // Low-power control bits; reserved positions are not stored
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wake_on_any_pending        <= SYSTEM_CTRL_RESET;
            deep_low_power_select      <= SYSTEM_CTRL_RESET;
            sleep_after_handler_return <= SYSTEM_CTRL_RESET;
        end else if (ce_in) begin
            if (wr_ok && avs_address_in == OFS_SYSTEM_CTRL) begin
                wake_on_any_pending <=
                    avs_writedata_in[WAKE_ON_ANY_PENDING_BIT];
                deep_low_power_select <=
                    avs_writedata_in[DEEP_LOW_POWER_SELECT_BIT];
                sleep_after_handler_return <=
                    avs_writedata_in[SLEEP_AFTER_RETURN_BIT];
            end
        end
    end

    // Reset request pulse; the debug bit is never acted on
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sys_reset_req_out <= 1'b0;
        end else if (ce_in) begin
            sys_reset_req_out <= wr_ok && key_ok
                && avs_address_in == OFS_APP_INTERRUPT_RESET_CTRL
                && avs_writedata_in[SYSTEM_RESET_REQUEST_BIT];
        end
    end

    // Disabled interrupts count only when wake-any is set
    assign qual_now = irq_pending_in
        & (irq_enable_in | {NUM_IRQ{wake_on_any_pending}});
    assign pend_rise = |(qual_now & ~qual_prev);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            qual_prev <= '0;
        end else if (ce_in) begin
            qual_prev <= qual_now;
        end
    end

    sysc_wake_latch u_wake (
        .clk_in        (clk_in),
        .reset_n_in    (reset_n_in),
        .ce_in         (ce_in),
        .pend_rise_in  (pend_rise),
        .event_in      (event_in),
        .send_event_in (send_event_in),
        .wait_enter_in (wait_enter_in),
        .waiting_out   (wait_raw),
        .wake_out      (wake_raw),
        .latched_out   (latched)
    );

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            waiting_out <= 1'b0;
            wake_out    <= 1'b0;
        end else if (ce_in) begin
            waiting_out <= wait_raw;
            wake_out    <= wake_raw;
        end
    end

    // Sleep entry by instruction or on return to thread mode
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sleep_out      <= 1'b0;
            deep_sleep_out <= 1'b0;
        end else if (ce_in) begin
            sleep_out <= sleep_enter_in
                | (handler_return_in & sleep_after_handler_return);
            deep_sleep_out <= deep_low_power_select;
        end
    end

    sysc_stack_align u_stack (
        .clk_in         (clk_in),
        .reset_n_in     (reset_n_in),
        .ce_in          (ce_in),
        .entry_in       (exc_entry_in),
        .return_in      (exc_return_in),
        .sp_in          (sp_in),
        .stacked_bit_in (stacked_bit_in),
        .sp_out         (sp_out),
        .status_bit_out (status_bit_out)
    );

    // Any access not aligned to its size traps
    always_comb begin
        case (data_size_in)
            SIZE_BYTE: misaligned = 1'b0;
            SIZE_HALF: misaligned = data_addr_in[0];
            default:   misaligned = |data_addr_in;
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hard_fault_out <= 1'b0;
        end else if (ce_in) begin
            hard_fault_out <= data_access_in & misaligned;
        end
    end

    a_key_guard: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && accept && avs_write_in
         && avs_address_in == OFS_APP_INTERRUPT_RESET_CTRL
         && avs_writedata_in[31:16] != 16'h05fa) |=> !sys_reset_req_out)
        else $error("unkeyed write requested reset");
    a_reset_request: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && accept && avs_write_in && avs_byteenable_in == 4'hf
         && avs_address_in == OFS_APP_INTERRUPT_RESET_CTRL
         && avs_writedata_in[31:16] == 16'h05fa && avs_writedata_in[2])
        |=> sys_reset_req_out ##1 !sys_reset_req_out)
        else $error("keyed reset request not a single pulse");
    a_reset_ctrl_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (accept && avs_read_in
         && avs_address_in == OFS_APP_INTERRUPT_RESET_CTRL)
        |-> (avs_readdata_out == {16'h0, BIG_ENDIAN, 15'h0}))
        else $error("reset control read value wrong");
    a_config_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (accept && avs_read_in && avs_address_in == OFS_CORE_CONFIG_CTRL)
        |-> (avs_readdata_out[9] && avs_readdata_out[3]
             && avs_readdata_out == 32'h0000_0208))
        else $error("configuration read value wrong");
    a_ctrl_readback: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && accept && avs_write_in && avs_byteenable_in == 4'hf
         && avs_address_in == OFS_SYSTEM_CTRL)
        |=> ({wake_on_any_pending, deep_low_power_select,
              sleep_after_handler_return}
             == {$past(avs_writedata_in[4]), $past(avs_writedata_in[2]),
                 $past(avs_writedata_in[1])}))
        else $error("control write not stored");
    a_bus_answer: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && (avs_read_in || avs_write_in) && avs_waitrequest_out)
        |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("bus answer not one cycle");
    a_exit_sleep: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && handler_return_in && !sleep_enter_in)
        |=> (sleep_out == $past(sleep_after_handler_return)))
        else $error("sleep on handler return wrong");
    a_deep_select: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        sleep_out |-> (deep_sleep_out == $past(deep_low_power_select)))
        else $error("low power mode select wrong");
    a_disabled_wake: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && !wake_on_any_pending && (qual_now != '0))
        |-> ((irq_pending_in & irq_enable_in) != '0))
        else $error("disabled interrupt counted for wake");
    a_misaligned_fault: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && data_access_in && data_size_in == 2'h2 && data_addr_in != 2'h0)
        |=> hard_fault_out)
        else $error("unaligned word access did not fault");
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking testbench for the system control register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module tb_top
    import sysc_pkg::*;
;
    localparam logic BE  = 1'b1;
    localparam [4:0] ARC = OFS_APP_INTERRUPT_RESET_CTRL;
    localparam [4:0] SC  = OFS_SYSTEM_CTRL;
    localparam [4:0] CC  = OFS_CORE_CONFIG_CTRL;
    logic        clk_in;
    logic        reset_n_in;
    logic [4:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0]  be;
    logic [3:0]  lanes;
    logic [31:0] pend;
    logic [31:0] enab;
    logic [7:0]  stb;
    logic [31:0] sp;
    logic        sbit;
    logic [1:0]  daddr;
    logic [1:0]  dsize;
    logic        rreq;
    logic        sleep;
    logic        deep;
    logic        waiting;
    logic        wake;
    logic [31:0] spo;
    logic        sbo;
    logic        hf;
    logic        wreq;
    logic [31:0] seed;
    int          fail_count = 0;
    int          n_checks = 0;
    int          wake_cnt = 0;
    int          rst_cnt = 0;

    sysc_regs #(.NUM_IRQ(32), .BIG_ENDIAN(BE)) u_sysc_regs (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .irq_pending_in(pend), .irq_enable_in(enab), .event_in(stb[0]),
        .send_event_in(stb[1]), .wait_enter_in(stb[2]),
        .sleep_enter_in(stb[3]), .handler_return_in(stb[4]),
        .exc_entry_in(stb[5]), .exc_return_in(stb[6]), .sp_in(sp),
        .stacked_bit_in(sbit), .data_access_in(stb[7]),
        .data_addr_in(daddr), .data_size_in(dsize),
        .sys_reset_req_out(rreq), .sleep_out(sleep),
        .deep_sleep_out(deep), .waiting_out(waiting), .wake_out(wake),
        .sp_out(spo), .status_bit_out(sbo), .hard_fault_out(hf));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Pulse counters sampled at the clock edge
    always @(posedge clk_in) begin
        if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
        if (rreq === 1'b1) rst_cnt <= rst_cnt + 1;
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic exp_fault(input int a, input int s);
        return (s == 1 && a[0]) || (s >= 2 && a != 0);
    endfunction

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_in);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        be <= lanes;
        do begin
            @(posedge clk_in);
        end while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wrt(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(q, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // Bits: event, send, wait, sleep, return, entry, exc return, access
    task automatic strobe(input int k);
        @(posedge clk_in);
        stb <= 8'h1 << k;
        @(posedge clk_in);
        stb <= 8'h0;
        #1;
    endtask

    initial begin
        logic [31:0] d;
        int c;
        reset_n_in = 1'b0;
        {rd, wr, sbit} = '0;
        {addr, wdata, pend, enab, stb, sp, daddr, dsize} = '0;
        be = 4'hf;
        lanes = 4'hf;
        seed = 32'h0d188a32;
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rdc(ARC, 32'(BE) << 15);
        rdc(SC, 32'h0);
        rdc(CC, (32'h1 << 9) | (32'h1 << 3));
        rdc(5'h10, 32'h0);
        $display("reset value test done");
        wrt(ARC, {16'h05fb, 16'h0004});
        idle(2);
        `CHK(rst_cnt, 0);
        wrt(ARC, {REGISTER_WRITE_KEY, 16'h0004});
        idle(2);
        `CHK(rst_cnt, 1);
        wrt(ARC, {REGISTER_WRITE_KEY, 16'(!BE) << 15});
        idle(2);
        `CHK(rst_cnt, 1);
        lanes = 4'h3;
        wrt(ARC, {REGISTER_WRITE_KEY, 16'h0004});
        lanes = 4'hf;
        idle(2);
        `CHK(rst_cnt, 1);
        rdc(ARC, 32'(BE) << 15);
        $display("reset control test done");
        for (int i = 0; i < 6; i++) begin
            d = rnd();
            wrt(SC, d);
            rdc(SC, d & 32'h16);
        end
        wrt(CC, rnd());
        rdc(CC, (32'h1 << 9) | (32'h1 << 3));
        $display("register access test done");
        for (int i = 0; i < 4; i++) begin
            wrt(SC, (32'(i[0]) << 2) | (32'(i[1]) << 1));
            strobe(3);
            `CHK({sleep, deep}, {1'b1, i[0]});
            strobe(4);
            `CHK(sleep, i[1]);
        end
        $display("sleep test done");
        wrt(SC, 32'h0);
        strobe(2);
        idle(1);
        `CHK(waiting, 1'b1);
        c = wake_cnt;
        strobe(1);
        idle(3);
        `CHK(wake_cnt - c, 1);
        `CHK(waiting, 1'b0);
        strobe(0);
        idle(3);
        c = wake_cnt;
        strobe(2);
        idle(3);
        `CHK(wake_cnt - c, 1);
        `CHK(waiting, 1'b0);
        strobe(2);
        idle(1);
        c = wake_cnt;
        d = rnd();
        @(posedge clk_in);
        pend <= 32'h1 << d[4:0];
        idle(4);
        `CHK(wake_cnt - c, 0);
        `CHK(waiting, 1'b1);
        @(posedge clk_in);
        pend <= 32'h0;
        wrt(SC, 32'h10);
        c = wake_cnt;
        d = rnd();
        pend <= 32'h1 << d[4:0];
        idle(4);
        `CHK(wake_cnt - c, 1);
        @(posedge clk_in);
        pend <= 32'h0;
        wrt(SC, 32'h0);
        strobe(2);
        d = rnd() | 32'h1;
        @(posedge clk_in);
        enab <= d;
        pend <= d;
        idle(4);
        `CHK(wake_cnt - c, 2);
        $display("wake test done");
        for (int i = 0; i < 4; i++) begin
            d = rnd();
            @(posedge clk_in);
            sp <= d;
            sbit <= d[7];
            strobe(5);
            `CHK(spo, d & ~32'h7);
            `CHK(sbo, d[2]);
            strobe(6);
            `CHK(spo, d | (32'(d[7]) << 2));
        end
        $display("stack test done");
        for (int a = 0; a < 4; a++) begin
            for (int s = 0; s < 4; s++) begin
                @(posedge clk_in);
                daddr <= a[1:0];
                dsize <= s[1:0];
                strobe(7);
                `CHK(hf, exp_fault(a, s));
            end
        end
        $display("fault test done");
        final_report();
    end

    initial begin
        #200000;
        fail_count++;
        final_report();
    end
endmodule
`default_nettype wire
